/* rtl/scd_pkg.sv */
/*
  Shared constants and types of the serial port control and clock-rate
  block: register addresses, field positions, reset values, the register
  access and pin carriers and the module state record.
  Assumes a byte-wide special-register space driven by the local core.
*/
package scd_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SCD_CKR_ADDR  = 8'h9D;
  localparam logic [7:0] SCD_CTL_ADDR  = 8'hF8;
  localparam logic [7:0] SCD_DAT_ADDR  = 8'hA3;
  localparam logic [7:0] SCD_RST_VAL   = 8'h00;

  // ----------------------------------------------------------------
  // Control/status field positions
  // ----------------------------------------------------------------
  localparam int SCD_DONE = 7;
  localparam int SCD_COLL  = 6;
  localparam int SCD_FAULT = 5;
  localparam int SCD_OVR  = 4;
  localparam int SCD_BUSY = 3;
  localparam int SCD_SLV  = 2;
  localparam int SCD_MST  = 1;
  localparam int SCD_EN   = 0;
  localparam logic [7:0] SCD_FLAG_MASK = 8'hF0;
  localparam logic [7:0] SCD_CTRL_MASK = 8'h03;

  // ----------------------------------------------------------------
  // Frame and buffer sizing
  // ----------------------------------------------------------------
  localparam logic [3:0] SCD_FRAME_BITS = 4'h8;
  localparam logic [3:0] SCD_LAST_BIT   = 4'h7;
  localparam logic [1:0] SCD_BUF_FULL   = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } scd_sfr_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic nss_n;
  } scd_pins_t;

  typedef struct packed {
    scd_pins_t       s1;
    scd_pins_t       s2;
    logic            sck_prev;
    logic [7:0]      ctl;
    logic [7:0]      ckr;
    logic [7:0]      shift;
    logic [3:0]      bits;
    logic [7:0]      div;
    logic            sck;
    logic            sck_oe;
    logic            mosi;
    logic            mosi_oe;
    logic            miso;
    logic            miso_oe;
    logic [1:0][7:0] buf_w;
    logic [1:0]      cnt;
    logic            wp;
    logic            rp;
    logic [7:0]      rdata;
    logic            irq;
  } scd_state_t;

endpackage : scd_pkg

/* rtl/scd_spi_ctrl.sv */
/*
  Serial port control/status, clock-rate divider, shifter and a two-entry
  receive buffer, reached through the special-register port.
  Assumes pins come from outside the clock domain; the enclosing pad ring
  resolves the enables into wires.
*/
// Summary of operation
// - Data write during transfer sets write collision
// - Collision flag raises the interrupt request
// - Collision flag clears only by software write
// - Eight-bit rate field sets serial clock frequency
// - Rate field used only in master mode
// - Serial clock divided from the system clock
`timescale 1ns/1ps
module scd_spi_ctrl (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Register port
  input  wire scd_pkg::scd_sfr_t  sfr_i,
  output logic [7:0]              sfr_rdata_o,
  output logic                    irq_o,
  // Serial pins
  input  wire scd_pkg::scd_pins_t pins_i,
  output logic                    sck_o,
  output logic                    sck_oe_o,
  output logic                    mosi_o,
  output logic                    mosi_oe_o,
  output logic                    miso_o,
  output logic                    miso_oe_o
);
  import scd_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic logic hit(input scd_sfr_t r, input logic [7:0] a);
    hit = r.addr == a;
  endfunction : hit

  scd_state_t q;
  scd_state_t d;

  logic       en;
  logic       mst;
  logic       sel;
  logic       push;
  logic [7:0] rx_byte;
  logic [7:0] set_f;
  logic       rise;
  logic       fall;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d       = q;
    push    = 1'b0;
    rx_byte = q.shift;
    set_f   = 8'h00;
    d.s1    = pins_i;
    d.s2    = q.s1;
    d.sck_prev = q.s2.sck;
    en   = q.ctl[SCD_EN];
    mst  = q.ctl[SCD_MST];
    sel  = en && !mst && !q.s2.nss_n;
    rise = q.s2.sck && !q.sck_prev;
    fall = !q.s2.sck && q.sck_prev;

    // Master shifting, clock divided from system clock
    if (en && mst && q.ctl[SCD_BUSY]) begin
      if (q.div == q.ckr) begin
        d.div = 8'h00;
        d.sck = !q.sck;
        if (!q.sck) begin
          d.shift = {q.shift[6:0], q.s2.miso};
          d.bits  = q.bits + 4'h1;
        end else if (q.bits == SCD_FRAME_BITS) begin
          d.ctl[SCD_BUSY] = 1'b0;
          push            = 1'b1;
          set_f[SCD_DONE] = 1'b1;
        end else begin
          d.mosi = q.shift[7];
        end
      end else begin
        d.div = q.div + 8'h01;
      end
    end

    // Out of master mode the clock parks low, even if cut mid-frame
    if (!(en && mst)) begin
      d.sck = 1'b0;
    end

    // Slave shifting on the external clock; rate field unused here
    d.ctl[SCD_SLV] = sel;
    if (sel) begin
      if (rise) begin
        d.shift = {q.shift[6:0], q.s2.mosi};
        d.ctl[SCD_BUSY] = 1'b1;
        if (q.bits == SCD_LAST_BIT) begin
          d.bits          = 4'h0;
          d.ctl[SCD_BUSY] = 1'b0;
          push            = 1'b1;
          rx_byte         = {q.shift[6:0], q.s2.mosi};
          set_f[SCD_DONE] = 1'b1;
        end else begin
          d.bits = q.bits + 4'h1;
        end
      end else if (fall) begin
        d.miso = q.shift[7];
      end
    end else if (!mst) begin
      d.bits          = 4'h0;
      d.ctl[SCD_BUSY] = 1'b0;
    end

    // Another master pulled select low: drop to slave
    if (en && mst && !q.s2.nss_n) begin
      set_f[SCD_FAULT] = 1'b1;
      d.ctl[SCD_MST]  = 1'b0;
      d.ctl[SCD_BUSY] = 1'b0;
      d.sck           = 1'b0;
    end

    // Register writes
    if (sfr_i.wr && hit(sfr_i, SCD_DAT_ADDR)) begin
      if (q.ctl[SCD_BUSY]) begin
        set_f[SCD_COLL] = 1'b1;
      end else if (en) begin
        d.shift = sfr_i.wdata;
        d.bits  = 4'h0;
        d.miso  = sfr_i.wdata[7];
        if (mst) begin
          d.ctl[SCD_BUSY] = 1'b1;
          d.div           = 8'h00;
          d.sck           = 1'b0;
          d.mosi          = sfr_i.wdata[7];
        end
      end
    end
    if (sfr_i.wr && hit(sfr_i, SCD_CTL_ADDR)) begin
      // Flags only clear from software; control bits load
      d.ctl = (d.ctl & ~(SCD_FLAG_MASK | SCD_CTRL_MASK))
            | (q.ctl & sfr_i.wdata & SCD_FLAG_MASK)
            | (sfr_i.wdata & SCD_CTRL_MASK);
    end
    if (sfr_i.wr && hit(sfr_i, SCD_CKR_ADDR)) begin
      d.ckr = sfr_i.wdata;
    end

    // Receive buffer: a full buffer refuses the word as overrun
    if (push) begin
      if (q.cnt == SCD_BUF_FULL) begin
        set_f[SCD_OVR] = 1'b1;
      end else begin
        d.buf_w[q.wp] = rx_byte;
        d.wp          = !q.wp;
      end
    end
    d.rdata = 8'h00;
    if (sfr_i.rd) begin
      if (hit(sfr_i, SCD_CTL_ADDR)) begin
        d.rdata = q.ctl;
      end else if (hit(sfr_i, SCD_CKR_ADDR)) begin
        d.rdata = q.ckr;
      end else if (hit(sfr_i, SCD_DAT_ADDR) && q.cnt != 2'h0) begin
        d.rdata = q.buf_w[q.rp];
        d.rp    = !q.rp;
      end
    end
    d.cnt = q.cnt
          + {1'b0, push && q.cnt != SCD_BUF_FULL}
          - {1'b0, sfr_i.rd && hit(sfr_i, SCD_DAT_ADDR) && q.cnt != 2'h0};

    // Set wins over a same-cycle software clear
    d.ctl     = d.ctl | set_f;
    d.irq     = |(d.ctl & SCD_FLAG_MASK);
    d.sck_oe  = d.ctl[SCD_EN] && d.ctl[SCD_MST];
    d.mosi_oe = d.ctl[SCD_EN] && d.ctl[SCD_MST];
    d.miso_oe = d.ctl[SCD_SLV];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata_o = q.rdata;
  assign irq_o       = q.irq;
  assign sck_o       = q.sck;
  assign sck_oe_o    = q.sck_oe;
  assign mosi_o      = q.mosi;
  assign mosi_oe_o   = q.mosi_oe;
  assign miso_o      = q.miso;
  assign miso_oe_o   = q.miso_oe;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  coll_on_write_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sfr_i.wr && hit(sfr_i, SCD_DAT_ADDR) && q.ctl[SCD_BUSY])
      |=> q.ctl[SCD_COLL])
    else $error("collision flag not set");

  coll_irq_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(q.ctl[SCD_COLL]) |-> irq_o)
    else $error("collision gave no interrupt");

  coll_sticky_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q.ctl[SCD_COLL] && !(sfr_i.wr && hit(sfr_i, SCD_CTL_ADDR)
      && !sfr_i.wdata[SCD_COLL])) |=> q.ctl[SCD_COLL])
    else $error("collision flag cleared by hardware");

  rate_toggle_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q.ctl[SCD_BUSY] && q.ctl[SCD_EN] && q.ctl[SCD_MST] && q.s2.nss_n
      && q.div == q.ckr && !(sfr_i.wr && hit(sfr_i, SCD_DAT_ADDR)))
      |=> sck_o != $past(sck_o))
    else $error("serial clock missed its divider edge");

  slave_no_sck_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !q.ctl[SCD_MST] ##1 !q.ctl[SCD_MST] |-> !sck_oe_o && !sck_o)
    else $error("slave drives serial clock");

  div_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (q.ctl[SCD_BUSY] && q.ctl[SCD_EN] && q.ctl[SCD_MST] && q.s2.nss_n
      && q.div != q.ckr && !(sfr_i.wr && hit(sfr_i, SCD_DAT_ADDR)))
      |=> $stable(sck_o) && q.div == $past(q.div) + 8'h01)
    else $error("serial clock moved off divider");

  reset_zero_a: assert property (
    @(posedge clk_i)
    $past(rst_i) |-> q.ctl == SCD_RST_VAL && q.ckr == SCD_RST_VAL
      && !irq_o)
    else $error("registers not zero after reset");

endmodule : scd_spi_ctrl

/* sim/scd_slave_model.sv */
/*
  Behavioural serial slave on the far side of the port, mode 0, MSB
  first. Each frame returns the previous reply plus 8'h11, from 8'h3C.
  Assumes reset is high at time zero and the clock idles low.
*/
`timescale 1ns/1ps
module scd_slave_model (
  // Control
  input  wire logic       rst_i,
  // Serial pins
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  // Last byte received
  output logic [7:0]      rx_o
);
  logic [7:0] tx_q = 8'h3C;
  logic [7:0] sh_q = 8'h3C;
  logic [2:0] n_q  = 3'h0;
  logic [7:0] rx_q = 8'h00;
  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  assign miso_o = sh_q[7];
  assign rx_o   = rx_q;
  always @(posedge sck_i) rx_q <= {rx_q[6:0], mosi_i};
  // Reset guard keeps the x-to-0 start of the clock from counting
  always @(negedge sck_i) begin
    if (!rst_i) begin
      n_q <= n_q + 3'h1;
      if (n_q == 3'h7) begin
        tx_q <= tx_q + 8'h11;
        sh_q <= tx_q + 8'h11;
      end else begin
        sh_q <= {sh_q[6:0], 1'b0};
      end
    end
  end
endmodule : scd_slave_model

/* sim/scd_spi_ctrl_bench.sv */
/*
  Self-checking bench of the serial port control block.
  Assumes the slave model on the master pins; the bench itself plays
  the external master in the slave scenario.
*/
`timescale 1ns/1ps
module scd_spi_ctrl_bench;
  import scd_pkg::*;
  logic       clk_i, rst_i, irq, sck, sck_oe, mosi, mosi_oe;
  logic       miso_d, miso_oe, miso;
  logic [7:0] rdata, rx;
  logic       s_sck, s_mosi, s_nss_n;
  scd_sfr_t   sfr_i;
  scd_pins_t  pins_i;
  int         n_errors = 0, n_compared = 0, cyc = 0;
  scd_spi_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr_i),
    .sfr_rdata_o(rdata), .irq_o(irq), .pins_i(pins_i), .sck_o(sck),
    .sck_oe_o(sck_oe), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
    .miso_o(miso_d), .miso_oe_o(miso_oe));
  scd_slave_model u_slv (.rst_i(rst_i), .sck_i(sck), .mosi_i(mosi),
    .miso_o(miso), .rx_o(rx));
  // External master pins, driven by the bench; select idles high
  assign pins_i = '{sck: s_sck, mosi: s_mosi, miso: miso, nss_n: s_nss_n};
  // ----------------------------------------------------------------
  // Clock, timeout, report
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end
  task results();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // ----------------------------------------------------------------
  // Bus tasks, all entered at a falling edge
  // ----------------------------------------------------------------
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_i = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_i) sfr_i.wr = 1'b0;
    @(negedge clk_i);
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    sfr_i = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_i) sfr_i.rd = 1'b0;
    d = rdata;
    @(negedge clk_i);
  endtask : rd
  task rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask : rchk
  // Polls the done flag; a hang shows in the next compare
  task wait_done();
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < 300 && d[7] !== 1'b1; i++) rd(SCD_CTL_ADDR, d);
  endtask : wait_done
  task half(input int e);
    int n;
    n = 0;
    for (int i = 0; i < 400 && sck !== 1'b1; i++) @(negedge clk_i);
    while (sck === 1'b1 && n < 400) begin
      n++;
      @(negedge clk_i);
    end
    chk(n[7:0], e[7:0]);
  endtask : half
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    rchk(SCD_CTL_ADDR, 8'h00);
    rchk(SCD_CKR_ADDR, 8'h00);
    rchk(8'h55, 8'h00);
    chk({7'h00, irq}, 8'h00);
  endtask : t_reset
  task t_rate();
    wr(SCD_CKR_ADDR, 8'h02);
    wr(SCD_CTL_ADDR, 8'h03);
    rchk(SCD_CKR_ADDR, 8'h02);
    chk({6'h00, sck_oe, mosi_oe}, 8'h03);
    wr(SCD_DAT_ADDR, 8'hA5);
    half(3);
    wait_done();
    chk(rx, 8'hA5);
    rchk(SCD_CTL_ADDR, 8'h83);
    chk({7'h00, irq}, 8'h01);
    wr(SCD_CTL_ADDR, 8'h03);
    rchk(SCD_DAT_ADDR, 8'h3C);
  endtask : t_rate
  task t_coll();
    wr(SCD_DAT_ADDR, 8'hC7);
    wr(SCD_DAT_ADDR, 8'h11);
    chk({7'h00, irq}, 8'h01);
    rchk(SCD_CTL_ADDR, 8'h4B);
    wait_done();
    chk(rx, 8'hC7);
    rchk(SCD_CTL_ADDR, 8'hC3);
    wr(SCD_CTL_ADDR, 8'hC3);
    rchk(SCD_CTL_ADDR, 8'hC3);
    wr(SCD_CTL_ADDR, 8'h03);
    rchk(SCD_CTL_ADDR, 8'h03);
    chk({7'h00, irq}, 8'h00);
    rchk(SCD_DAT_ADDR, 8'h4D);
  endtask : t_coll
  // Three frames unread: the third finds the buffer full
  // Done is cleared first, so each poll waits for its own frame
  task t_buf();
    wr(SCD_CKR_ADDR, 8'h05);
    repeat (3) begin
      wr(SCD_CTL_ADDR, 8'h03);
      wr(SCD_DAT_ADDR, 8'h5A);
      half(6);
      wait_done();
      chk(rx, 8'h5A);
    end
    rchk(SCD_CTL_ADDR, 8'h93);
    rchk(SCD_DAT_ADDR, 8'h5E);
    rchk(SCD_DAT_ADDR, 8'h6F);
    rchk(SCD_DAT_ADDR, 8'h00);
    wr(SCD_CTL_ADDR, 8'h03);
  endtask : t_buf
  // Select pulled low under a master: fault, slave, one frame
  task t_slave();
    logic       seen;
    logic [7:0] got;
    logic [7:0] tx;
    seen = 1'b0;
    got  = 8'h00;
    tx   = 8'hB4;
    wr(SCD_CKR_ADDR, 8'h00);
    s_nss_n = 1'b0;
    repeat (6) @(negedge clk_i);
    rchk(SCD_CTL_ADDR, 8'h25);
    chk({7'h00, irq}, 8'h01);
    wr(SCD_CTL_ADDR, 8'h01);
    rchk(SCD_CTL_ADDR, 8'h05);
    chk({7'h00, miso_oe}, 8'h01);
    wr(SCD_DAT_ADDR, 8'h96);
    // Half period of four cycles stays above the sync delay
    for (int i = 7; i >= 0; i--) begin
      s_mosi = tx[i];
      repeat (4) @(negedge clk_i);
      s_sck = 1'b1;
      got   = {got[6:0], miso_d};
      repeat (4) @(negedge clk_i);
      seen  = seen | sck_oe | sck;
      s_sck = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    chk({7'h00, seen}, 8'h00);
    chk(got, 8'h96);
    rchk(SCD_CTL_ADDR, 8'h85);
    rchk(SCD_DAT_ADDR, 8'hB4);
    s_nss_n = 1'b1;
    wr(SCD_CTL_ADDR, 8'h00);
  endtask : t_slave
  // Reset in mid-run clears the rate and control values written just before it
  task t_rerun();
    wr(SCD_CKR_ADDR, 8'h7E);
    wr(SCD_CTL_ADDR, 8'h03);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
  endtask : t_rerun
  initial begin
    sfr_i   = '0;
    s_sck   = 1'b0;
    s_mosi  = 1'b0;
    s_nss_n = 1'b1;
    rst_i   = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
    t_rate();
    t_coll();
    t_buf();
    t_slave();
    t_rerun();
    results();
  end
endmodule : scd_spi_ctrl_bench
